// File: hdl/ubr_top.sv
// module: buffer-ready flag register, summary flag and interrupt for endpoints 0 to 6
//
// Summary of operation
// (R1) upper bits 15..7 of the flag register are written zero and read zero
// (R2) bits 6..0 hold one ready flag per endpoint, bit n for endpoint n
// (R3) a flag reads 1 after its ready condition, 0 otherwise
// (R4) ready means the cpu or dma side may access the endpoint buffer
// (R5) clear mode 0: software writes to the flags are ignored
// (R6) clear mode 1: writing 0 clears a flag, writing 1 does nothing
// (R7) enable and any flag set raise the summary bit and interrupt
// (R8) endpoint 0 control write: flag sets on buffer-valid rise
// (R9) endpoint 0 control write, clear mode 0: flag clears on valid fall
// (R10) endpoint 0 control read: flag never sets
// (R11) out endpoint, not dma-owned or dma mode 1: set on valid rise
// (R12) dma-owned out endpoint, dma mode 0: set when buffer drained
// (R13) out endpoint, clear mode 0: flag clears on valid fall
// (R14) dma-owned out, mode 0: software pulses buffer clear to drop valid
// (R15) in endpoint, not dma-owned: set on valid fall or data-end rise
// (R16) dma-owned in endpoint, dma mode 0: flag never sets
// (R17) in endpoint, clear mode 0: flag clears on valid rise
// (R18) summary bit 8 clears only when every flag is zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module ubr_top (
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rd_data_o,
	// buffer side status from the fifo logic
	input wire ubr_pkg::ubr_buf_s buf_i,
	// results
	output logic [6:0] endpoint_ready_flags_o,
	output logic ready_summary_flag_o,
	output logic ready_irq_o,
	output logic [6:0] buffer_clear_o,
	output logic irq_o
);

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	wire hit_status = ubr_pkg::ubr_hit(addr_i, ubr_pkg::OFS_READY_STATUS);
	wire hit_ctrl = ubr_pkg::ubr_hit(addr_i, ubr_pkg::OFS_READY_CTRL);
	wire hit_summary = ubr_pkg::ubr_hit(addr_i, ubr_pkg::OFS_SUMMARY);
	wire hit_evt = ubr_pkg::ubr_hit(addr_i, ubr_pkg::OFS_EVT_STATUS);
	wire hit_mask = ubr_pkg::ubr_hit(addr_i, ubr_pkg::OFS_EVT_MASK);
	wire hit_buffer_clear = ubr_pkg::ubr_hit(addr_i, ubr_pkg::OFS_BUF_CLEAR);

	wire wr_status = wr_i & hit_status;
	wire wr_ctrl = wr_i & hit_ctrl;
	wire wr_evt = wr_i & hit_evt;
	wire wr_mask = wr_i & hit_mask;
	wire wr_buffer_clear = wr_i & hit_buffer_clear;

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	ubr_pkg::ubr_ctrl_s ctrl_ff;
	ubr_pkg::ubr_ctrl_s nxt_ctrl;

	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl.ready_clear_mode = wr_data_i[ubr_pkg::CTRL_CLR_MODE_BIT];
			nxt_ctrl.ready_irq_enable = wr_data_i[ubr_pkg::CTRL_IRQ_EN_BIT];
			nxt_ctrl.dma_irq_mode = wr_data_i[ubr_pkg::CTRL_DMA_MODE_BIT];
			nxt_ctrl.dma_endpoint_select =
				wr_data_i[ubr_pkg::CTRL_DMA_SEL_LSB +: ubr_pkg::SEL_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= '0;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// ---------------------------------------------------------------
	// software clear of flags
	// ---------------------------------------------------------------
	// only the low seven bits matter; bits 15..7 are dropped on write [R1]
	wire [6:0] wr_flag_bits = wr_data_i[6:0];
	wire sw_clr_ok = wr_status & ctrl_ff.ready_clear_mode; // [R5]
	wire [6:0] sw_clr = {7{sw_clr_ok}} & ~wr_flag_bits; // [R6]

	// ---------------------------------------------------------------
	// per-endpoint flags
	// ---------------------------------------------------------------
	logic [6:0] flags;
	logic [6:0] flag_set;

	// one flag per endpoint, index equals bit position
	for (genvar g = 0; g < ubr_pkg::EP_NUM; g++) begin : g_ep
		ubr_ep_flag #(
			.EP_IDX(3'(g))
		) u_flag (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.valid_i(buf_i.buffer_valid[g]),
			.dir_i(buf_i.endpoint_direction[g]),
			.data_end_i(buf_i.endpoint_data_end[g]),
			.dma_done_i(buf_i.dma_read_done),
			.dma_sel_i(ctrl_ff.dma_endpoint_select),
			.dma_mode_i(ctrl_ff.dma_irq_mode),
			.clr_mode_i(ctrl_ff.ready_clear_mode),
			.sw_clr_i(sw_clr[g]),
			.flag_o(flags[g]), // [R2]
			.set_o(flag_set[g])
		);
	end

	// ---------------------------------------------------------------
	// summary flag
	// ---------------------------------------------------------------
	logic summary_ff;
	logic nxt_summary;
	wire any_flag = |flags;

	// summary follows the flag flops one cycle later
	assign nxt_summary = (ctrl_ff.ready_irq_enable & any_flag) // [R7]
		| (summary_ff & any_flag); // [R18]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			summary_ff <= 1'b0;
		end else begin
			summary_ff <= nxt_summary;
		end
	end

	// ---------------------------------------------------------------
	// event status and mask
	// ---------------------------------------------------------------
	logic [6:0] evt_ff;
	logic [6:0] nxt_evt;
	logic [6:0] mask_ff;
	logic [6:0] nxt_mask;
	logic irq_ff;
	logic nxt_irq;

	// a set in the clearing cycle survives the write-one-to-clear
	assign nxt_evt = flag_set | (evt_ff & ~({7{wr_evt}} & wr_data_i[6:0]));
	assign nxt_mask = wr_mask ? wr_data_i[6:0] : mask_ff;
	assign nxt_irq = |(nxt_evt & nxt_mask);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_ff <= ubr_pkg::RST_EVT;
			mask_ff <= ubr_pkg::RST_MASK;
			irq_ff <= 1'b0;
		end else begin
			evt_ff <= nxt_evt;
			mask_ff <= nxt_mask;
			irq_ff <= nxt_irq;
		end
	end

	// ---------------------------------------------------------------
	// buffer clear pulses
	// ---------------------------------------------------------------
	// the fifo logic holds valid high for a dma-owned out endpoint in
	// mode 0, so software must pulse this to release the buffer
	logic [6:0] buffer_clear_ff;
	wire [6:0] nxt_buffer_clear = {7{wr_buffer_clear}} & wr_data_i[6:0]; // [R14]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buffer_clear_ff <= 7'h00;
		end else begin
			buffer_clear_ff <= nxt_buffer_clear;
		end
	end

	// ---------------------------------------------------------------
	// read back
	// ---------------------------------------------------------------
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	wire [15:0] rd_status = {9'h000, flags}; // [R1] [R3]
	wire [15:0] rd_ctrl = {9'h000,
		ctrl_ff.dma_endpoint_select,
		1'b0,
		ctrl_ff.dma_irq_mode,
		ctrl_ff.ready_irq_enable,
		ctrl_ff.ready_clear_mode};
	wire [15:0] rd_summary = {7'h00, summary_ff, 8'h00};
	wire [15:0] rd_evt = {9'h000, evt_ff};
	wire [15:0] rd_mask = {9'h000, mask_ff};

	// unmapped addresses and idle cycles read zero
	always_comb begin
		nxt_rdata = ubr_pkg::RST_RDATA;
		if (rd_i) begin
			if (hit_status) begin
				nxt_rdata = rd_status;
			end else if (hit_ctrl) begin
				nxt_rdata = rd_ctrl;
			end else if (hit_summary) begin
				nxt_rdata = rd_summary;
			end else if (hit_evt) begin
				nxt_rdata = rd_evt;
			end else if (hit_mask) begin
				nxt_rdata = rd_mask;
			end else begin
				nxt_rdata = ubr_pkg::RST_RDATA;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_ff <= ubr_pkg::RST_RDATA;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign rd_data_o = rdata_ff;
	assign endpoint_ready_flags_o = flags;
	assign ready_summary_flag_o = summary_ff;
	assign ready_irq_o = summary_ff; // [R7]
	assign buffer_clear_o = buffer_clear_ff;
	assign irq_o = irq_ff;

endmodule
`default_nettype wire

// File: hdl/ubr_pkg.sv
// package: register map, field layout and carriers of the buffer-ready flag block
`default_nettype none
package ubr_pkg;

	// ---------------------------------------------------------------
	// sizes
	// ---------------------------------------------------------------
	localparam int unsigned EP_NUM = 7;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned SEL_W = 3;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_READY_STATUS = 8'h1a;
	localparam logic [7:0] OFS_READY_CTRL = 8'h20;
	localparam logic [7:0] OFS_SUMMARY = 8'h22;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h24;
	localparam logic [7:0] OFS_EVT_MASK = 8'h26;
	localparam logic [7:0] OFS_BUF_CLEAR = 8'h28;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int unsigned CTRL_CLR_MODE_BIT = 0;
	localparam int unsigned CTRL_IRQ_EN_BIT = 1;
	localparam int unsigned CTRL_DMA_MODE_BIT = 2;
	localparam int unsigned CTRL_DMA_SEL_LSB = 4;
	localparam int unsigned SUMMARY_BIT = 8;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [6:0] RST_FLAGS = 7'h00;
	localparam logic [6:0] RST_EVT = 7'h00;
	localparam logic [6:0] RST_MASK = 7'h00;
	localparam logic [15:0] RST_RDATA = 16'h0000;
	localparam logic [2:0] RST_DMA_SEL = 3'h0;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	// bit 0 of direction is the endpoint 0 control-read select
	typedef struct packed {
		logic [6:0] buffer_valid;
		logic [6:0] endpoint_direction;
		logic [6:0] endpoint_data_end;
		logic dma_read_done;
	} ubr_buf_s;

	typedef struct packed {
		logic [2:0] dma_endpoint_select;
		logic dma_irq_mode;
		logic ready_irq_enable;
		logic ready_clear_mode;
	} ubr_ctrl_s;

	function automatic logic ubr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		ubr_hit = (addr == ofs);
	endfunction

endpackage
`default_nettype wire

// File: hdl/ubr_ep_flag.sv
// module: one endpoint's buffer-ready flag with its set and clear conditions
`timescale 1ns/10ps
`default_nettype none
module ubr_ep_flag #(
	parameter logic [2:0] EP_IDX = 3'h0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic valid_i,
	input wire logic dir_i,
	input wire logic data_end_i,
	input wire logic dma_done_i,
	input wire logic [2:0] dma_sel_i,
	input wire logic dma_mode_i,
	input wire logic clr_mode_i,
	input wire logic sw_clr_i,
	output logic flag_o,
	output logic set_o
);
	logic valid_ff;
	logic der_ff;
	logic flag_ff;
	logic nxt_flag;
	wire is_ep0 = (EP_IDX == 3'h0);
	wire v_rise = valid_i & ~valid_ff;
	wire v_fall = ~valid_i & valid_ff;
	wire der_rise = data_end_i & ~der_ff;
	// a dma-owned out endpoint with interrupt mode 0 reports on drain, not on valid; a dma-owned in endpoint never reports
	wire dma_owned = ~is_ep0 & (dma_sel_i == EP_IDX) & ~dma_mode_i;
	wire set_ep0 = ~dir_i & v_rise; // [R8] [R10]
	wire set_out = dma_owned ? dma_done_i : v_rise; // [R11] [R12]
	wire set_in = ~dma_owned & (v_fall | der_rise); // [R15] [R16]
	wire hw_clr_ep0 = ~dir_i & v_fall & ~clr_mode_i; // [R9]
	wire hw_clr_out = v_fall & ~clr_mode_i; // [R13]
	wire hw_clr_in = v_rise & ~clr_mode_i; // [R17]
	wire set_any = is_ep0 ? set_ep0 : (dir_i ? set_in : set_out);
	wire hw_clr = is_ep0 ? hw_clr_ep0 : (dir_i ? hw_clr_in : hw_clr_out);

	// set beats either clear in the same cycle
	assign nxt_flag = set_any | (flag_ff & ~(hw_clr | sw_clr_i)); // [R3] [R4]
	assign flag_o = flag_ff;
	assign set_o = set_any;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_ff <= 1'b0;
			der_ff <= 1'b0;
			flag_ff <= 1'b0;
		end else begin
			valid_ff <= valid_i;
			der_ff <= data_end_i;
			flag_ff <= nxt_flag;
		end
	end

endmodule
`default_nettype wire

// File: test/ubr_far_model.sv
// partner model: endpoint buffer state as the fifo and dma side present it
`timescale 1ns/10ps
`default_nettype none
module ubr_far_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [6:0] set_i,
	input wire logic [6:0] drop_i,
	input wire logic [6:0] dir_i,
	input wire logic [6:0] der_i,
	input wire logic done_i,
	input wire logic [6:0] clear_i,
	output var ubr_pkg::ubr_buf_s buf_o
);
	logic [6:0] v_ff;
	// a buffer stays valid until the test drops it or software pulses its clear
	always_ff @(posedge clk_i) begin
		if (rst_i) v_ff <= 7'h00;
		else v_ff <= (v_ff | set_i) & ~(drop_i | clear_i);
	end
	assign buf_o = {v_ff, dir_i, der_i, done_i};
endmodule
`default_nettype wire

// File: test/ubr_top_chk.sv
// checker: port-level properties of the buffer-ready flag block
`timescale 1ns/10ps
`default_nettype none
module ubr_top_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rd_data_o,
	input wire ubr_pkg::ubr_buf_s buf_i,
	input wire logic [6:0] endpoint_ready_flags_o,
	input wire logic ready_summary_flag_o,
	input wire logic ready_irq_o,
	input wire logic [6:0] buffer_clear_o
);
	// ---------------------------------------------------------------
	// shadow of the control register
	// ---------------------------------------------------------------
	logic [6:0] ctl_ff;
	wire logic [6:0] fl = endpoint_ready_flags_o;
	wire logic [6:0] v = buf_i.buffer_valid;
	wire logic [6:0] dr = buf_i.endpoint_direction;
	wire logic m1 = ctl_ff[0];
	wire logic sw = wr_i && addr_i == 8'h1a;
	wire logic hit28 = wr_i && addr_i == 8'h28;
	wire logic [6:0] wd = wr_data_i[6:0];
	always_ff @(posedge clk_i) begin
		if (rst_i) ctl_ff <= 7'h00;
		else if (wr_i && addr_i == 8'h20) ctl_ff <= wr_data_i[6:0];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_read_layout: assert property (rd_i && addr_i == 8'h1a
		|=> rd_data_o == {9'h000, $past(fl)})
		else $error("flag read wrong");
	a_ep0_set: assert property (!dr[0] && $rose(v[0]) |=> fl[0])
		else $error("ep0 flag not set");
	a_ep0_never: assert property (dr[0] && !fl[0] |=> !fl[0])
		else $error("ep0 read flag set");
	a_out_set: assert property (!dr[1] && $rose(v[1]) && ctl_ff[6:4] != 3'h1 |=> fl[1])
		else $error("out flag not set");
	a_out_clear: assert property (!m1 && !dr[3] && $fell(v[3])
		&& !buf_i.dma_read_done |=> !fl[3])
		else $error("out flag not cleared");
	a_in_set: assert property (dr[4] && $fell(v[4]) && ctl_ff[6:4] != 3'h4 |=> fl[4])
		else $error("in flag not set");
	a_sw_ignored: assert property (!m1 && sw && fl[1] && $stable(v[1]) |=> fl[1])
		else $error("write changed flag");
	a_sw_clear: assert property (m1 && sw && !wd[3] && !$rose(v[3])
		&& !$fell(v[3]) && !$rose(buf_i.endpoint_data_end[3])
		&& !buf_i.dma_read_done |=> !fl[3])
		else $error("write did not clear");
	a_summary_set: assert property (ctl_ff[1] && fl != 7'h00
		|=> ready_summary_flag_o && ready_irq_o)
		else $error("summary not raised");
	a_summary_hold: assert property (ready_summary_flag_o
		|=> ready_summary_flag_o == ($past(fl) != 7'h00))
		else $error("summary wrong");
	a_clear_pulse: assert property (1'b1
		|=> buffer_clear_o == ($past(hit28) ? $past(wd) : 7'h00))
		else $error("clear pulse wrong");
	c_dma_done: cover property (buf_i.dma_read_done && fl == 7'h00);
	c_sw_clear: cover property (m1 && sw);
	c_summary_drop: cover property ($fell(ready_summary_flag_o));
endmodule
bind ubr_top ubr_top_chk ubr_top_chk_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
	.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .buf_i(buf_i),
	.endpoint_ready_flags_o(endpoint_ready_flags_o), .ready_summary_flag_o(ready_summary_flag_o),
	.ready_irq_o(ready_irq_o), .buffer_clear_o(buffer_clear_o));
`default_nettype wire

// File: test/tb.sv
// testbench: register, flag and interrupt checks of the buffer-ready block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [15:0] wr_data_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [6:0] set_v = 7'h00, drop_v = 7'h00, dir = 7'h00, der = 7'h00;
	logic done = 1'b0;
	logic rd_seen = 1'b0;
	wire logic [15:0] rd_data_o;
	wire logic [6:0] clr;
	wire logic irq_o;
	wire ubr_pkg::ubr_buf_s buf_w;
	logic [15:0] exp_q[$];
	int mismatches = 0;
	int comparisons = 0;
	int seed = 31;
	always #5 clk_i = ~clk_i;
	ubr_far_model ubr_far_model_i (.clk_i(clk_i), .rst_i(rst_i), .set_i(set_v), .drop_i(drop_v),
		.dir_i(dir), .der_i(der), .done_i(done), .clear_i(clr), .buf_o(buf_w));
	ubr_top ubr_top_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .buf_i(buf_w),
		.endpoint_ready_flags_o(), .ready_summary_flag_o(), .ready_irq_o(),
		.buffer_clear_o(clr), .irq_o(irq_o));
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		exp_q.push_back(e);
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	// one-cycle buffer-side pulses, then time for flag and summary to settle
	task automatic pulse(input logic [6:0] s, input logic [6:0] d, input logic dn);
		@(posedge clk_i);
		set_v <= s;
		drop_v <= d;
		done <= dn;
		@(posedge clk_i);
		set_v <= 7'h00;
		drop_v <= 7'h00;
		done <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) rd_seen <= rd_i;
	always @(negedge clk_i) if (rd_seen) chk("rd_data", rd_data_o, exp_q.pop_front());
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h1a, 16'h0000);
		rd(8'h22, 16'h0000);
		rd(8'h30, 16'h0000);
		dir <= 7'h70;
		wr(8'h20, 16'h0002);
		pulse(7'h0f, 7'h00, 1'b0);
		rd(8'h1a, 16'h000f);
		rd(8'h22, 16'h0100);
		repeat (4) begin
			wr(8'h1a, {9'h000, 7'($random(seed))});
			rd(8'h1a, 16'h000f);
		end
		pulse(7'h00, 7'h0f, 1'b0);
		rd(8'h1a, 16'h0000);
		rd(8'h22, 16'h0000);
		pulse(7'h70, 7'h00, 1'b0);
		pulse(7'h00, 7'h70, 1'b0);
		rd(8'h1a, 16'h0070);
		pulse(7'h10, 7'h00, 1'b0);
		rd(8'h1a, 16'h0060);
		der <= 7'h10;
		repeat (4) @(posedge clk_i);
		rd(8'h1a, 16'h0070);
		wr(8'h20, 16'h0003);
		wr(8'h1a, 16'h005f);
		rd(8'h1a, 16'h0050);
		pulse(7'h40, 7'h00, 1'b0);
		rd(8'h1a, 16'h0050);
		wr(8'h1a, 16'h0000);
		rd(8'h22, 16'h0000);
		wr(8'h20, 16'h0022);
		pulse(7'h04, 7'h00, 1'b0);
		rd(8'h1a, 16'h0000);
		pulse(7'h00, 7'h00, 1'b1);
		rd(8'h1a, 16'h0004);
		wr(8'h28, 16'h0004);
		repeat (4) @(posedge clk_i);
		rd(8'h1a, 16'h0000);
		wr(8'h20, 16'h0062);
		pulse(7'h00, 7'h40, 1'b0);
		rd(8'h1a, 16'h0000);
		dir <= 7'h71;
		pulse(7'h01, 7'h00, 1'b0);
		rd(8'h1a, 16'h0000);
		rd(8'h24, 16'h007f);
		@(negedge clk_i);
		chk("irq", {15'h0000, irq_o}, 16'h0000);
		wr(8'h26, 16'h0002);
		repeat (2) @(negedge clk_i);
		chk("irq", {15'h0000, irq_o}, 16'h0001);
		wr(8'h24, 16'h0002);
		repeat (2) @(negedge clk_i);
		chk("irq", {15'h0000, irq_o}, 16'h0000);
		rd(8'h24, 16'h007d);
		rd(8'h26, 16'h0002);
		repeat (3) @(posedge clk_i);
		final_report();
	end
endmodule
`default_nettype wire
